// ---- hdl/fri_pkg.sv ----
// Constants shared by the free-running capture timer and its leaf modules.
// Assumes a 16-bit register port with word indices; nothing else.
`default_nettype none
// ****************************************************************
// Widths and counts
// ****************************************************************
package fri_pkg;
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 4;
  localparam int N_CH   = 4;
  localparam int SEL_W  = 2;
  localparam int PRE_W  = 3;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_COUNT     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CAP_CTRL  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CAP_STAT  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CAP_DATA0 = 4'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_CLR      = 2;
  localparam int CTRL_HALT     = 3;
  localparam int CTRL_OVF_IE   = 4;
  localparam int CTRL_OVF_XFER = 5;
  localparam int CTRL_OVF_FLAG = 6;
  localparam int CAP_EDGE_LSB  = 0;
  localparam int CAP_IE_LSB    = 8;
  localparam int CAP_XFER_LSB  = 12;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RST   = 2'h0;

  // Edge selection per capture channel
  typedef enum logic [1:0] {
    FRI_EDGE_OFF  = 2'h0,
    FRI_EDGE_RISE = 2'h1,
    FRI_EDGE_FALL = 2'h2,
    FRI_EDGE_BOTH = 2'h3
  } fri_edge_t;
endpackage
`default_nettype wire

// ---- hdl/fri_prescaler.sv ----
// Machine clock divider giving the count-enable pulse of the timer.
// Assumes sel and run come from registers on the same clock.
`timescale 1ns/10ps
`default_nettype none
module fri_prescaler #(
  parameter int PRE_W = fri_pkg::PRE_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  input  wire logic [fri_pkg::SEL_W-1:0] sel,
  input  wire logic                     run,
  input  wire logic                     restart,
  output logic                          tick
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } fri_pre_state_t;

  fri_pre_state_t q;
  fri_pre_state_t next_q;
  logic [PRE_W-1:0] mask;

  // Ratio 8 needs three divider bits; refuse narrower builds
  if (PRE_W < 3) begin : g_bad_pre_w
    $error("fri_prescaler: PRE_W too small for four ratios");
  end

  // Ratio 1, 2, 4 or 8 by masking the low divider bits
  always_comb begin
    mask   = PRE_W'((1 << sel) - 1);
    tick   = run && ((q.cnt & mask) == mask);
    next_q = q;
    if (restart || !run) begin
      next_q.cnt = '0; // Restart keeps phase aligned to a clear
    end else begin
      next_q.cnt = q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/fri_capture_chan.sv ----
// One capture channel: pin synchroniser, edge detector, captured count.
// Assumes pin is asynchronous and count is the live timer value.
`timescale 1ns/10ps
`default_nettype none
module fri_capture_chan #(
  parameter int WIDTH = fri_pkg::CNT_W
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              pin,
  input  wire fri_pkg::fri_edge_t edge_mode,
  input  wire logic [WIDTH-1:0]  count,
  output logic                   hit,
  output logic [WIDTH-1:0]       value
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic             primed;
    logic             level;
    logic             hit;
    logic [WIDTH-1:0] value;
  } fri_cap_state_t;

  fri_cap_state_t q;
  fri_cap_state_t next_q;
  logic           agree;
  logic           rise;
  logic           fall;

  // A zero-width stamp cannot hold a count
  if (WIDTH < 1) begin : g_bad_width
    $error("fri_capture_chan: WIDTH must be positive");
  end

  // Three stages; a change counts once stages two and three agree
  always_comb begin
    next_q     = q;
    next_q.s1  = pin;
    next_q.s2  = q.s1;
    next_q.s3  = q.s2;
    agree      = (q.s2 == q.s3);
    rise       = agree && q.primed && q.s3 && !q.level;
    fall       = agree && q.primed && !q.s3 && q.level;
    if (agree) begin
      next_q.level  = q.s3;
      next_q.primed = 1'b1; // First agreement only learns the level
    end
    case (edge_mode)
      fri_pkg::FRI_EDGE_RISE: next_q.hit = rise;
      fri_pkg::FRI_EDGE_FALL: next_q.hit = fall;
      fri_pkg::FRI_EDGE_BOTH: next_q.hit = rise || fall;
      default:                next_q.hit = 1'b0;
    endcase
    if (next_q.hit) begin
      next_q.value = count;
    end
  end

  assign hit   = q.hit;
  assign value = q.value;

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/fri_timer.sv ----
// Free-running 16-bit timer with four edge capture channels.
// Assumes a synchronous register port on ref_clk and asynchronous pins.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module fri_timer #(
  parameter int N_CH = fri_pkg::N_CH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [fri_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [fri_pkg::CNT_W-1:0]   reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [fri_pkg::CNT_W-1:0]        reg_rdata,
  input  wire logic [N_CH-1:0]             cap_pin,
  output logic [fri_pkg::CNT_W-1:0]        timer_count_value,
  output logic                             ovf_irq,
  output logic                             ovf_xfer_req,
  input  wire logic                        ovf_xfer_ack,
  output logic [N_CH-1:0]                  cap_irq,
  output logic [N_CH-1:0]                  cap_xfer_req,
  input  wire logic [N_CH-1:0]             cap_xfer_ack
);
  localparam int W = fri_pkg::CNT_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [W-1:0]              count;
    logic [fri_pkg::SEL_W-1:0] clk_sel;
    logic                      halt;
    logic                      ovf_ie;
    logic                      ovf_xfer;
    logic                      ovf_flag;
    logic [2*N_CH-1:0]         edge_sel;
    logic [N_CH-1:0]           cap_ie;
    logic [N_CH-1:0]           cap_xfer;
    logic [N_CH-1:0]           cap_flag;
    logic [W-1:0]              rdata;
  } fri_timer_state_t;

  fri_timer_state_t q;
  fri_timer_state_t next_q;

  logic               tick;
  logic               wr_count;
  logic               wr_ctrl;
  logic               wr_cap_ctrl;
  logic               wr_cap_stat;
  logic               clr_req;
  logic               ovf_set;
  logic               ovf_clr;
  logic [N_CH-1:0]    cap_hit;
  logic [N_CH-1:0]    cap_clr;
  logic [W-1:0]       cap_value [N_CH];
  logic [W-1:0]       rd_mux;

  // Register map holds exactly four capture data words
  if (N_CH != fri_pkg::N_CH) begin : g_bad_n_ch
    $error("fri_timer: N_CH must equal four");
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Single-cycle write strobes per register
  assign wr_count    = reg_wr && (reg_addr == fri_pkg::ADDR_COUNT);
  assign wr_ctrl     = reg_wr && (reg_addr == fri_pkg::ADDR_CTRL);
  assign wr_cap_ctrl = reg_wr && (reg_addr == fri_pkg::ADDR_CAP_CTRL);
  assign wr_cap_stat = reg_wr && (reg_addr == fri_pkg::ADDR_CAP_STAT);
  assign clr_req     = wr_ctrl && reg_wdata[fri_pkg::CTRL_CLR];

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  // A clear also restarts the divider so the first count is full length
  fri_prescaler #(
    .PRE_W   (fri_pkg::PRE_W)
  ) u_pre (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .sel     (q.clk_sel),
    .run     (!q.halt),
    .restart (clr_req),
    .tick    (tick)
  );

  // ****************************************************************
  // Capture channels
  // ****************************************************************
  // One unit per pin; channels are independent
  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_ch
      fri_capture_chan #(
        .WIDTH     (W)
      ) u_ch (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .pin       (cap_pin[gi]),
        .edge_mode (fri_pkg::fri_edge_t'(q.edge_sel[2*gi +: 2])),
        .count     (q.count),
        .hit       (cap_hit[gi]),
        .value     (cap_value[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Event flags
  // ****************************************************************
  // Overflow is the all-ones count taking a tick
  assign ovf_set = tick && (q.count == {W{1'b1}}) && !clr_req;
  // Software writes zero to the flag, or the transfer service acknowledges
  assign ovf_clr = (wr_ctrl && !reg_wdata[fri_pkg::CTRL_OVF_FLAG]) || ovf_xfer_ack;
  // Write one to clear capture flags, or acknowledge from transfer service
  assign cap_clr = (wr_cap_stat ? reg_wdata[N_CH-1:0] : '0) | cap_xfer_ack;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Unmapped indices read zero; clear bit always reads zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      fri_pkg::ADDR_COUNT: begin
        rd_mux = q.count;
      end
      fri_pkg::ADDR_CTRL: begin
        rd_mux[fri_pkg::CTRL_SEL_LSB +: fri_pkg::SEL_W] = q.clk_sel;
        rd_mux[fri_pkg::CTRL_HALT]                      = q.halt;
        rd_mux[fri_pkg::CTRL_OVF_IE]                    = q.ovf_ie;
        rd_mux[fri_pkg::CTRL_OVF_XFER]                  = q.ovf_xfer;
        rd_mux[fri_pkg::CTRL_OVF_FLAG]                  = q.ovf_flag;
      end
      fri_pkg::ADDR_CAP_CTRL: begin
        rd_mux[fri_pkg::CAP_EDGE_LSB +: 2*N_CH] = q.edge_sel;
        rd_mux[fri_pkg::CAP_IE_LSB +: N_CH]     = q.cap_ie;
        rd_mux[fri_pkg::CAP_XFER_LSB +: N_CH]   = q.cap_xfer;
      end
      fri_pkg::ADDR_CAP_STAT: begin
        rd_mux[N_CH-1:0] = q.cap_flag;
      end
      default: begin
        for (int i = 0; i < N_CH; i++) begin
          if (reg_addr == fri_pkg::ADDR_CAP_DATA0 + fri_pkg::ADDR_W'(i)) begin
            rd_mux = cap_value[i];
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_q = q;

    // Counter: clear beats load beats tick
    if (clr_req) begin
      next_q.count = fri_pkg::COUNT_RST;
    end else if (wr_count && q.halt) begin
      next_q.count = reg_wdata;
    end else if (tick) begin
      next_q.count = q.count + 1'b1;
    end

    // Control fields
    if (wr_ctrl) begin
      next_q.clk_sel  = reg_wdata[fri_pkg::CTRL_SEL_LSB +: fri_pkg::SEL_W];
      next_q.halt     = reg_wdata[fri_pkg::CTRL_HALT];
      next_q.ovf_ie   = reg_wdata[fri_pkg::CTRL_OVF_IE];
      next_q.ovf_xfer = reg_wdata[fri_pkg::CTRL_OVF_XFER];
    end
    if (wr_cap_ctrl) begin
      next_q.edge_sel = reg_wdata[fri_pkg::CAP_EDGE_LSB +: 2*N_CH];
      next_q.cap_ie   = reg_wdata[fri_pkg::CAP_IE_LSB +: N_CH];
      next_q.cap_xfer = reg_wdata[fri_pkg::CAP_XFER_LSB +: N_CH];
    end

    // Sticky flags; a same-cycle event wins over its clear
    next_q.ovf_flag = (q.ovf_flag && !ovf_clr) || ovf_set;
    next_q.cap_flag = (q.cap_flag & ~cap_clr) | cap_hit;

    // Read data stands one cycle after the strobe
    next_q.rdata = reg_rd ? rd_mux : '0;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Request routed either to the processor or to the transfer service
  assign ovf_irq      = q.ovf_flag && q.ovf_ie && !q.ovf_xfer;
  assign ovf_xfer_req = q.ovf_flag && q.ovf_ie && q.ovf_xfer;
  assign cap_irq      = q.cap_flag & q.cap_ie & ~q.cap_xfer;
  assign cap_xfer_req = q.cap_flag & q.cap_ie & q.cap_xfer;
  assign timer_count_value = q.count;
  assign reg_rdata    = q.rdata;

  // ****************************************************************
  // State register
  // ****************************************************************
  // Everything resets to zero, counter included
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ---- verification/fri_pin_src.sv ----
// Model of the external signal sources that drive the capture pins.
// Assumes the bench sets the wanted levels at a clock edge.
`timescale 1ns/10ps
`default_nettype none
module fri_pin_src #(
  parameter int N_CH = fri_pkg::N_CH
) (
  input  wire logic [N_CH-1:0] level,
  output var  logic [N_CH-1:0] cap_pin
);
  // Skewed off the edge: a real source has no phase relation to the clock
  always @(level) begin
    cap_pin <= #37 level;
  end
  initial cap_pin = '0;
endmodule
`default_nettype wire

// ---- verification/fri_timer_sva.sv ----
// Checker for the free-running capture timer; sees only its top ports.
// Assumes control state changes only through register writes.
`timescale 1ns/10ps
`default_nettype none
module fri_timer_sva #(
  parameter int N_CH = fri_pkg::N_CH
) (
  input wire logic                       ref_clk,
  input wire logic                       arst_n,
  input wire logic [fri_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fri_pkg::CNT_W-1:0]  reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [fri_pkg::CNT_W-1:0]  reg_rdata,
  input wire logic [N_CH-1:0]            cap_pin,
  input wire logic [fri_pkg::CNT_W-1:0]  timer_count_value,
  input wire logic                       ovf_irq,
  input wire logic                       ovf_xfer_req,
  input wire logic                       ovf_xfer_ack,
  input wire logic [N_CH-1:0]            cap_irq,
  input wire logic [N_CH-1:0]            cap_xfer_req,
  input wire logic [N_CH-1:0]            cap_xfer_ack
);
  // ****************************************************************
  // Shadow of control words, so properties know the mode in force
  // ****************************************************************
  logic [15:0] ctrl_q;
  logic [15:0] cap_q;
  logic        jump_ok;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= 16'h0000;
      cap_q   <= 16'h0000;
      jump_ok <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == fri_pkg::ADDR_CTRL) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == fri_pkg::ADDR_CAP_CTRL) cap_q <= reg_wdata;
      // Clear or a halted load may move the count off its step
      jump_ok <= reg_wr && (reg_addr == fri_pkg::ADDR_CTRL || (reg_addr == fri_pkg::ADDR_COUNT && ctrl_q[3]));
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Count passes the all-ones value into zero with the bus quiet
  sequence s_wrap;
    (timer_count_value == 16'hFFFF && !reg_wr) ##1 (timer_count_value == 16'h0000 && !reg_wr);
  endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not zero");
  AST_RD_COUNT: assert property (
    reg_rd && reg_addr == fri_pkg::ADDR_COUNT |=> reg_rdata == $past(timer_count_value))
    else $error("count read not live");
  AST_STEP: assert property (
    $changed(timer_count_value) |-> jump_ok || timer_count_value == $past(timer_count_value) + 16'h0001)
    else $error("count moved off its step");
  AST_HALT: assert property (ctrl_q[3] && !reg_wr |=> $stable(timer_count_value)) else $error("halted count moved");
  AST_LOAD: assert property (
    reg_wr && reg_addr == fri_pkg::ADDR_COUNT && ctrl_q[3] |=> timer_count_value == $past(reg_wdata))
    else $error("halted load lost");
  AST_CLEAR: assert property (
    reg_wr && reg_addr == fri_pkg::ADDR_CTRL && reg_wdata[2] |=> timer_count_value == 16'h0000)
    else $error("clear did not zero count");
  AST_WRAP: assert property (
    s_wrap |-> ##[0:1] (ovf_irq == (ctrl_q[4] && !ctrl_q[5]) && ovf_xfer_req == (ctrl_q[4] && ctrl_q[5])))
    else $error("overflow request missing");
  AST_OVF_HOLD: assert property (ovf_irq && !reg_wr && !ovf_xfer_ack |=> ovf_irq) else $error("overflow flag dropped");
  AST_EXCL: assert property (!(ovf_irq && ovf_xfer_req) && (cap_irq & cap_xfer_req) == '0) else $error("both routes");
  AST_CAP_RISE: assert property (
    $rose(cap_pin[0]) && cap_q[0] && cap_q[8] && !cap_q[12] |-> ##[3:6] cap_irq[0])
    else $error("capture request late");
  AST_CAP_HOLD: assert property (
    !reg_wr && cap_xfer_ack == '0 |=> (cap_irq & $past(cap_irq)) == $past(cap_irq))
    else $error("capture flag dropped");
endmodule
bind fri_timer fri_timer_sva #(.N_CH(N_CH)) u_fri_timer_sva (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_pin(cap_pin),
  .timer_count_value(timer_count_value), .ovf_irq(ovf_irq), .ovf_xfer_req(ovf_xfer_req), .ovf_xfer_ack(ovf_xfer_ack),
  .cap_irq(cap_irq), .cap_xfer_req(cap_xfer_req), .cap_xfer_ack(cap_xfer_ack));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the free-running capture timer.
// Assumes package, design, pin model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        ref_clk;
  logic        arst_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  level;
  logic [3:0]  cap_pin;
  logic [15:0] timer_count_value;
  logic        ovf_irq;
  logic        ovf_xfer_req;
  logic        ovf_xfer_ack;
  logic [3:0]  cap_irq;
  logic [3:0]  cap_xfer_req;
  logic [3:0]  cap_xfer_ack;
  logic [15:0] rv;
  int          mismatches;
  int          num_checks;
  int          cycles;

  fri_timer u_fri_timer (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_pin(cap_pin),
    .timer_count_value(timer_count_value), .ovf_irq(ovf_irq), .ovf_xfer_req(ovf_xfer_req),
    .ovf_xfer_ack(ovf_xfer_ack), .cap_irq(cap_irq), .cap_xfer_req(cap_xfer_req), .cap_xfer_ack(cap_xfer_ack));
  fri_pin_src u_fri_pin_src (.level(level), .cap_pin(cap_pin));

  // ****************************************************************
  // Clock, watchdog on the run length, shared tasks
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_clear();
    wr(4'h8, 16'hFFFF);
    rd(4'h8, rv);
    chk("unmapped", rv, 16'h0000);
    wr(fri_pkg::ADDR_CTRL, 16'h000C);
    rd(fri_pkg::ADDR_COUNT, rv);
    chk("count after clear", rv, 16'h0000);
    rd(fri_pkg::ADDR_CTRL, rv);
    chk("control readback", rv, 16'h0008);
  endtask
  // Unhalt at E, halt taken at E+17: ticks at multiples of the ratio
  task automatic t_prescale();
    for (int s = 0; s < 4; s++) begin
      wr(fri_pkg::ADDR_CTRL, 16'h0008);
      wr(fri_pkg::ADDR_COUNT, 16'h0000);
      wr(fri_pkg::ADDR_CTRL, 16'(s));
      repeat (15) @(posedge ref_clk);
      wr(fri_pkg::ADDR_CTRL, 16'h0008);
      rd(fri_pkg::ADDR_COUNT, rv);
      chk("prescaled count", rv, 16'(17 >> s));
    end
    wr(fri_pkg::ADDR_COUNT, 16'h0100);
    wr(fri_pkg::ADDR_CTRL, 16'h0003);
    wr(fri_pkg::ADDR_COUNT, 16'hAAAA);
    wr(fri_pkg::ADDR_CTRL, 16'h000B);
    rd(fri_pkg::ADDR_COUNT, rv);
    chk("load while running", rv, 16'h0100);
    // Clear at C mid-period; divider restart keeps the count at zero through C+7
    wr(fri_pkg::ADDR_CTRL, 16'h0003);
    repeat (5) @(posedge ref_clk);
    wr(fri_pkg::ADDR_CTRL, 16'h0007);
    repeat (5) @(posedge ref_clk);
    wr(fri_pkg::ADDR_CTRL, 16'h000B);
    rd(fri_pkg::ADDR_COUNT, rv);
    chk("restart on clear", rv, 16'h0000);
  endtask
  task automatic t_overflow();
    wr(fri_pkg::ADDR_COUNT, 16'hFFFE);
    wr(fri_pkg::ADDR_CTRL, 16'h0010);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("overflow irq", 16'(ovf_irq), 16'h0001);
    rd(fri_pkg::ADDR_CTRL, rv);
    chk("overflow flag", rv, 16'h0050);
    wr(fri_pkg::ADDR_CTRL, 16'h0078);
    #1;
    chk("overflow route", 16'({ovf_irq, ovf_xfer_req}), 16'h0001);
    rd(fri_pkg::ADDR_COUNT, rv);
    chk("count after wrap", rv, 16'h0006);
    @(posedge ref_clk);
    ovf_xfer_ack <= 1'b1;
    @(posedge ref_clk);
    ovf_xfer_ack <= 1'b0;
    #1;
    chk("overflow acked", 16'(ovf_xfer_req), 16'h0000);
    wr(fri_pkg::ADDR_CTRL, 16'h0008);
  endtask
  // Every channel, every edge mode; count halted so the stamp is exact
  task automatic t_capture();
    logic [15:0] val;
    logic [15:0] exp;
    logic [15:0] last [4];
    logic [1:0]  m;
    logic        hit;
    for (int i = 0; i < 4; i++) begin
      for (int k = 1; k < 5; k++) begin
        m   = 2'(k);
        val = 16'h1000 + 16'(i * 16 + k);
        wr(fri_pkg::ADDR_COUNT, val);
        wr(fri_pkg::ADDR_CAP_CTRL, (16'(m) << (2 * i)) | (16'h0100 << i) | ((m == 2'h3) ? (16'h1000 << i) : 16'h0));
        for (int e = 0; e < 2; e++) begin
          level[i] <= (e == 0);
          repeat (8) @(posedge ref_clk);
          #1;
          hit = (e == 0) ? m[0] : m[1];
          exp = hit ? (16'h0001 << i) : 16'h0000;
          chk("capture irq", 16'(cap_irq), (m == 2'h3) ? 16'h0000 : exp);
          chk("capture xfer", 16'(cap_xfer_req), (m == 2'h3) ? exp : 16'h0000);
          if (hit) last[i] = val;
          rd(fri_pkg::ADDR_CAP_DATA0 + 4'(i), rv);
          chk("capture data", rv, last[i]);
          if (m == 2'h3) begin
            @(posedge ref_clk);
            cap_xfer_ack[i] <= 1'b1;
            @(posedge ref_clk);
            cap_xfer_ack <= 4'h0;
          end else begin
            wr(fri_pkg::ADDR_CAP_STAT, 16'h000F);
          end
          #1;
          chk("capture cleared", 16'(cap_irq | cap_xfer_req), 16'h0000);
        end
      end
    end
  endtask

  initial begin
    arst_n       = 1'b0;
    reg_addr     = 4'h0;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    level        = 4'h0;
    ovf_xfer_ack = 1'b0;
    cap_xfer_ack = 4'h0;
    mismatches   = 0;
    num_checks   = 0;
    cycles       = 0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    chk("count at reset", timer_count_value, 16'h0000);
    t_clear();
    t_prescale();
    t_overflow();
    t_capture();
    close_out();
  end
endmodule
`default_nettype wire
